//--- logic/scu_consts.svh
// Purpose: shared constants of the serial unit (counts, reset values, line levels)
// Assumes: one core clock; bit timing derived from a 16x tick
// Notes: definitions only
`ifndef SCU_CONSTS_SVH
`define SCU_CONSTS_SVH

// oversampling: sixteen ticks per bit period
`define SCU_TICK_LAST      4'hf
// tick index at which the sync clock rises (centre of bit)
`define SCU_TICK_MID_PRE   4'h7
// start detect preload: sample lands 8 ticks after the edge tick (16 - 8)
`define SCU_RX_START_LOAD  4'h8
`define SCU_SYNC_BITS      4'h8
`define SCU_IDX_ZERO       4'h0
`define SCU_BYTE_RST       8'h00
`define SCU_FRAME_RST      12'h000
`define SCU_DIV_RST        16'h0000
`define SCU_LINE_IDLE      1'b1

`endif

//--- logic/scu_pkg.sv
// Purpose: state types of the serial unit
// Assumes: nothing beyond the constants header
// Notes: encodings left to the tool
package scu_pkg;

	typedef enum logic [0:0] {TX_IDLE, TX_RUN} scu_tx_state_t;
	typedef enum logic [0:0] {RX_IDLE, RX_RUN} scu_rx_state_t;

endpackage : scu_pkg

//--- logic/scu_sync3.sv
// Purpose: three-stage pin synchroniser with agreement filter
// Assumes: input is asynchronous to the clock
// Notes: the level changes only once stages two and three agree
`timescale 1ns/1ps
`include "scu_consts.svh"

module scu_sync3
(
	// clock and reset
	input  wire logic clk,
	input  wire logic rst_n,
	// pin side
	input  wire logic pin_in,
	// filtered level
	output logic      level_out
);

	logic s1_r;
	logic s2_r;
	logic s3_r;
	logic level_nxt;

	always_comb
	begin
		level_nxt = level_out;
		if (s2_r == s3_r)
		begin
			level_nxt = s3_r;
		end
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			s1_r      <= `SCU_LINE_IDLE;
			s2_r      <= `SCU_LINE_IDLE;
			s3_r      <= `SCU_LINE_IDLE;
			level_out <= `SCU_LINE_IDLE;
		end
		else
		begin
			s1_r      <= pin_in;
			s2_r      <= s1_r;
			s3_r      <= s2_r;
			level_out <= level_nxt;
		end
	end

endmodule : scu_sync3

//--- logic/scu_pair_buf.sv
// Purpose: two-entry byte buffer with valid/ready on both sides
// Assumes: same clock on both sides
// Notes: head and tail registers; outputs come straight from flops
`timescale 1ns/1ps
`include "scu_consts.svh"

module scu_pair_buf
(
	// clock and reset
	input  wire logic       clk,
	input  wire logic       rst_n,
	// fill side
	input  wire logic       in_valid,
	input  wire logic [7:0] in_data,
	output logic            in_ready,
	// drain side
	output logic            out_valid,
	output logic      [7:0] out_data,
	input  wire logic       out_ready
);

	logic [7:0] tail_r;
	logic       tail_v_r;
	logic [7:0] head_nxt;
	logic       head_v_nxt;
	logic [7:0] tail_nxt;
	logic       tail_v_nxt;
	logic       push;
	logic       pop;

	assign in_ready = !tail_v_r;

	always_comb
	begin
		head_nxt   = out_data;
		head_v_nxt = out_valid;
		tail_nxt   = tail_r;
		tail_v_nxt = tail_v_r;
		pop        = out_ready && out_valid;
		push       = in_valid && !tail_v_r;
		if (pop)
		begin
			head_nxt   = tail_r;
			head_v_nxt = tail_v_r;
			tail_v_nxt = 1'b0;
		end
		if (push)
		begin
			if (!head_v_nxt)
			begin
				head_nxt   = in_data;
				head_v_nxt = 1'b1;
			end
			else
			begin
				tail_nxt   = in_data;
				tail_v_nxt = 1'b1;
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			out_data  <= `SCU_BYTE_RST;
			out_valid <= 1'b0;
			tail_r    <= `SCU_BYTE_RST;
			tail_v_r  <= 1'b0;
		end
		else
		begin
			out_data  <= head_nxt;
			out_valid <= head_v_nxt;
			tail_r    <= tail_nxt;
			tail_v_r  <= tail_v_nxt;
		end
	end

endmodule : scu_pair_buf

//--- logic/scu_serial_unit.sv
// Purpose: serial_comm_unit transmit path, receive path and error flags
// Assumes: BAUD_DIV + 1 core clocks per 16x tick; config stable while busy
// Notes: received bytes drain through a two-entry buffer; a stall keeps
//        the receive-full flag set and so leads to overrun
`timescale 1ns/1ps
`include "scu_consts.svh"

// Notes on behaviour
// - A write to the transmit holding register is taken at any time, whatever the empty flag shows.
// - A write while the empty flag is clear replaces the pending byte, which is never sent unless a load takes it in that same cycle.
// - An overrun sets the overrun flag and any coinciding framing and parity flags, keeps receive-full and drops the byte.
// - Framing or parity errors without overrun set their flags, leave receive-full clear and still store the byte.
// - A continuous low line gives a framing error with zero stored as the byte.
// - During a break the receiver keeps framing, so a cleared framing flag is set again.
// - In asynchronous mode the sampling tick runs at sixteen times the bit rate.
// - The start edge is found by sampling the receive line on every tick.
// - Every bit of the frame, start, parity and stop included, is sampled at the bit centre.
// - Asynchronous frames from 9 to 12 bit periods are supported.
// - In synchronous mode no transmission starts while the overrun flag is set.
// - A byte completing while receive-full is still set is an overrun.
// - The receive-error request is the OR of the overrun, framing and parity flags.
module scu_serial_unit
	import scu_pkg::*;
(
	// clock and reset
	input  wire logic        CORE_CLK,
	input  wire logic        RST_N,
	// configuration
	input  wire logic        SYNC_MODE,
	input  wire logic        TX_EN,
	input  wire logic        RX_EN,
	input  wire logic        DATA7,
	input  wire logic        PARITY_EN,
	input  wire logic        PARITY_ODD,
	input  wire logic        TWO_STOP,
	input  wire logic [15:0] BAUD_DIV,
	// transmit holding register write
	input  wire logic        TX_WR,
	input  wire logic  [7:0] TX_DATA,
	// flag clears
	input  wire logic        RX_FULL_CLR,
	input  wire logic        OVR_CLR,
	input  wire logic        FER_CLR,
	input  wire logic        PER_CLR,
	// received byte stream
	output logic       [7:0] RX_DATA,
	output logic             RX_VALID,
	input  wire logic        RX_READY,
	// line
	input  wire logic        RXD,
	output logic             TXD,
	output logic             SCK_OUT,
	// status
	output logic             TX_EMPTY,
	output logic             RX_FULL,
	output logic             OVERRUN,
	output logic             FRAMING_ERR,
	output logic             PARITY_ERR,
	output logic             RX_ERR_REQ,
	output logic       [7:0] RX_HOLD
);

	// number of data bits for the current format
	function automatic logic [3:0] f_dbits(input logic d7);
		f_dbits = d7 ? 4'h7 : 4'h8;
	endfunction : f_dbits

	// total frame length, 9 to 12 bit periods
	function automatic logic [3:0] f_len(input logic d7, input logic pe, input logic two);
		f_len = 4'h1 + f_dbits(d7) + {3'h0, pe} + (two ? 4'h2 : 4'h1);
	endfunction : f_len

	function automatic logic f_par(input logic [7:0] d, input logic d7, input logic odd);
		f_par = (d7 ? ^d[6:0] : ^d) ^ odd;
	endfunction : f_par

	logic              rxd_s;
	logic              buf_in_ready;
	logic       [15:0] div_r;
	logic       [15:0] div_nxt;
	logic              tick;
	// transmit group
	scu_tx_state_t     tx_state_r;
	scu_tx_state_t     tx_state_nxt;
	logic       [11:0] tx_sh_r;
	logic       [11:0] tx_sh_nxt;
	logic        [3:0] tx_len_r;
	logic        [3:0] tx_len_nxt;
	logic        [3:0] tx_idx_r;
	logic        [3:0] tx_idx_nxt;
	logic        [3:0] tx_tc_r;
	logic        [3:0] tx_tc_nxt;
	logic        [7:0] tx_hold_r;
	logic        [7:0] tx_hold_nxt;
	logic              tx_empty_nxt;
	logic              txd_nxt;
	logic              sck_nxt;
	logic              sck_rise;
	// receive group
	scu_rx_state_t     rx_state_r;
	scu_rx_state_t     rx_state_nxt;
	logic       [11:0] rx_sh_r;
	logic       [11:0] rx_sh_nxt;
	logic        [3:0] rx_idx_r;
	logic        [3:0] rx_idx_nxt;
	logic        [3:0] rx_tc_r;
	logic        [3:0] rx_tc_nxt;
	logic              rx_prev_r;
	logic              rx_prev_nxt;
	logic              brk_r;
	logic              brk_nxt;
	logic        [7:0] rx_hold_nxt;
	logic              full_nxt;
	logic              ovr_nxt;
	logic              fer_nxt;
	logic              per_nxt;
	logic              done;
	logic              fe;
	logic              pe;
	logic        [7:0] rdat;
	logic        [3:0] pidx;
	logic        [3:0] sidx;

	scu_sync3 u_rxd_sync
	(
		.clk       (CORE_CLK),
		.rst_n     (RST_N),
		.pin_in    (RXD),
		.level_out (rxd_s)
	);

	scu_pair_buf u_rx_buf
	(
		.clk       (CORE_CLK),
		.rst_n     (RST_N),
		.in_valid  (RX_FULL),
		.in_data   (RX_HOLD),
		.in_ready  (buf_in_ready),
		.out_valid (RX_VALID),
		.out_data  (RX_DATA),
		.out_ready (RX_READY)
	);

	// 16x sampling tick from the bit-rate divider
	always_comb
	begin
		tick    = (div_r == `SCU_DIV_RST);
		div_nxt = tick ? BAUD_DIV : div_r - 16'h0001;
	end

	always_ff @(posedge CORE_CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			div_r <= `SCU_DIV_RST;
		end
		else
		begin
			div_r <= div_nxt;
		end
	end

	// transmit path
	always_comb
	begin
		tx_state_nxt = tx_state_r;
		tx_sh_nxt    = tx_sh_r;
		tx_len_nxt   = tx_len_r;
		tx_idx_nxt   = tx_idx_r;
		tx_tc_nxt    = tx_tc_r;
		tx_hold_nxt  = tx_hold_r;
		tx_empty_nxt = TX_EMPTY;
		txd_nxt      = TXD;
		sck_nxt      = SCK_OUT;
		sck_rise     = 1'b0;
		case (tx_state_r)
			TX_IDLE:
			begin
				if (!SYNC_MODE)
				begin
					txd_nxt = `SCU_LINE_IDLE;
				end
				// a set overrun flag holds off synchronous starts
				if (TX_EN && !TX_EMPTY && !(SYNC_MODE && OVERRUN))
				begin
					if (SYNC_MODE)
					begin
						tx_sh_nxt  = {4'h0, tx_hold_r};
						tx_len_nxt = `SCU_SYNC_BITS;
						sck_nxt    = 1'b0;
					end
					else
					begin
						tx_sh_nxt = 12'hfff;
						tx_sh_nxt[0] = 1'b0;
						tx_sh_nxt[8:1] = DATA7 ? {1'b1, tx_hold_r[6:0]} : tx_hold_r;
						if (PARITY_EN)
						begin
							tx_sh_nxt[f_dbits(DATA7) + 4'h1] = f_par(tx_hold_r, DATA7, PARITY_ODD);
						end
						tx_len_nxt = f_len(DATA7, PARITY_EN, TWO_STOP);
					end
					txd_nxt      = SYNC_MODE ? tx_hold_r[0] : 1'b0;
					tx_idx_nxt   = `SCU_IDX_ZERO;
					tx_tc_nxt    = `SCU_IDX_ZERO;
					tx_empty_nxt = 1'b1;
					tx_state_nxt = TX_RUN;
				end
			end
			TX_RUN:
			begin
				if (tick)
				begin
					tx_tc_nxt = tx_tc_r + 4'h1;
					if (SYNC_MODE && tx_tc_r == `SCU_TICK_MID_PRE)
					begin
						sck_nxt  = 1'b1;
						sck_rise = 1'b1;
					end
					if (tx_tc_r == `SCU_TICK_LAST)
					begin
						if (tx_idx_r + 4'h1 == tx_len_r)
						begin
							tx_state_nxt = TX_IDLE;
						end
						else
						begin
							tx_idx_nxt = tx_idx_r + 4'h1;
							txd_nxt    = tx_sh_r[tx_idx_r + 4'h1];
							sck_nxt    = !SYNC_MODE;
						end
					end
				end
			end
			default:
			begin
				tx_state_nxt = TX_IDLE;
			end
		endcase
		// the write wins over a same-cycle load; a pending byte is replaced
		if (TX_WR)
		begin
			tx_hold_nxt  = TX_DATA;
			tx_empty_nxt = 1'b0;
		end
	end

	always_ff @(posedge CORE_CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			tx_state_r <= TX_IDLE;
			tx_sh_r    <= `SCU_FRAME_RST;
			tx_len_r   <= `SCU_IDX_ZERO;
			tx_idx_r   <= `SCU_IDX_ZERO;
			tx_tc_r    <= `SCU_IDX_ZERO;
			tx_hold_r  <= `SCU_BYTE_RST;
			TX_EMPTY   <= 1'b1;
			TXD        <= `SCU_LINE_IDLE;
			SCK_OUT    <= 1'b1;
		end
		else
		begin
			tx_state_r <= tx_state_nxt;
			tx_sh_r    <= tx_sh_nxt;
			tx_len_r   <= tx_len_nxt;
			tx_idx_r   <= tx_idx_nxt;
			tx_tc_r    <= tx_tc_nxt;
			tx_hold_r  <= tx_hold_nxt;
			TX_EMPTY   <= tx_empty_nxt;
			TXD        <= txd_nxt;
			SCK_OUT    <= sck_nxt;
		end
	end

	// receive path and error flags
	always_comb
	begin
		rx_state_nxt = rx_state_r;
		rx_sh_nxt    = rx_sh_r;
		rx_idx_nxt   = rx_idx_r;
		rx_tc_nxt    = rx_tc_r;
		rx_prev_nxt  = rx_prev_r;
		brk_nxt      = brk_r;
		rx_hold_nxt  = RX_HOLD;
		done         = 1'b0;
		fe           = 1'b0;
		pe           = 1'b0;
		if (tick)
		begin
			rx_prev_nxt = rxd_s;
		end
		if (SYNC_MODE)
		begin
			rx_state_nxt = RX_IDLE;
			// synchronous data is taken on the rising clock edge
			if (sck_rise && RX_EN)
			begin
				rx_sh_nxt[rx_idx_r] = rxd_s;
				rx_idx_nxt = rx_idx_r + 4'h1;
				if (rx_idx_r == `SCU_SYNC_BITS - 4'h1)
				begin
					done       = 1'b1;
					rx_idx_nxt = `SCU_IDX_ZERO;
				end
			end
		end
		else
		begin
			case (rx_state_r)
				RX_IDLE:
				begin
					rx_idx_nxt = `SCU_IDX_ZERO;
					if (rxd_s)
					begin
						brk_nxt = 1'b0;
					end
					// after a zero stop bit a still-low line starts the next frame
					if (RX_EN && tick && !rxd_s && (rx_prev_r || brk_r))
					begin
						rx_tc_nxt    = `SCU_RX_START_LOAD;
						rx_state_nxt = RX_RUN;
					end
				end
				RX_RUN:
				begin
					if (tick)
					begin
						rx_tc_nxt = rx_tc_r + 4'h1;
						if (rx_tc_r == `SCU_TICK_LAST)
						begin
							rx_sh_nxt[rx_idx_r] = rxd_s;
							rx_idx_nxt = rx_idx_r + 4'h1;
							if (rx_idx_r == `SCU_IDX_ZERO && rxd_s)
							begin
								// glitch, not a start bit
								rx_state_nxt = RX_IDLE;
							end
							else if (rx_idx_r + 4'h1 == f_len(DATA7, PARITY_EN, TWO_STOP))
							begin
								done         = 1'b1;
								brk_nxt      = !rxd_s;
								rx_state_nxt = RX_IDLE;
							end
						end
					end
				end
				default:
				begin
					rx_state_nxt = RX_IDLE;
				end
			endcase
		end
		rdat = DATA7 ? {1'b0, rx_sh_nxt[7:1]} : rx_sh_nxt[8:1];
		pidx = f_dbits(DATA7) + 4'h1;
		sidx = pidx + {3'h0, PARITY_EN};
		if (SYNC_MODE)
		begin
			rdat = rx_sh_nxt[7:0];
		end
		else
		begin
			// a line held low yields zero data and a zero stop bit
			fe = !rx_sh_nxt[sidx] || (TWO_STOP && !rx_sh_nxt[sidx + 4'h1]);
			pe = PARITY_EN && (rx_sh_nxt[pidx] != f_par(rdat, DATA7, PARITY_ODD));
		end
		full_nxt = RX_FULL && !RX_FULL_CLR && !buf_in_ready;
		ovr_nxt  = OVERRUN && !OVR_CLR;
		fer_nxt  = FRAMING_ERR && !FER_CLR;
		per_nxt  = PARITY_ERR && !PER_CLR;
		if (done)
		begin
			if (RX_FULL)
			begin
				// keep the old byte and full flag; flag every coinciding error
				full_nxt = 1'b1;
				ovr_nxt  = 1'b1;
				fer_nxt  = fer_nxt || fe;
				per_nxt  = per_nxt || pe;
			end
			else if (!OVERRUN)
			begin
				// bytes are dropped until software clears a pending overrun
				rx_hold_nxt = rdat;
				full_nxt    = !fe && !pe;
				fer_nxt     = fer_nxt || fe;
				per_nxt     = per_nxt || pe;
			end
		end
	end

	always_ff @(posedge CORE_CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			rx_state_r  <= RX_IDLE;
			rx_sh_r     <= `SCU_FRAME_RST;
			rx_idx_r    <= `SCU_IDX_ZERO;
			rx_tc_r     <= `SCU_IDX_ZERO;
			rx_prev_r   <= `SCU_LINE_IDLE;
			brk_r       <= 1'b0;
			RX_HOLD     <= `SCU_BYTE_RST;
			RX_FULL     <= 1'b0;
			OVERRUN     <= 1'b0;
			FRAMING_ERR <= 1'b0;
			PARITY_ERR  <= 1'b0;
			RX_ERR_REQ  <= 1'b0;
		end
		else
		begin
			rx_state_r  <= rx_state_nxt;
			rx_sh_r     <= rx_sh_nxt;
			rx_idx_r    <= rx_idx_nxt;
			rx_tc_r     <= rx_tc_nxt;
			rx_prev_r   <= rx_prev_nxt;
			brk_r       <= brk_nxt;
			RX_HOLD     <= rx_hold_nxt;
			RX_FULL     <= full_nxt;
			OVERRUN     <= ovr_nxt;
			FRAMING_ERR <= fer_nxt;
			PARITY_ERR  <= per_nxt;
			RX_ERR_REQ  <= ovr_nxt || fer_nxt || per_nxt;
		end
	end

endmodule : scu_serial_unit

//--- testbench/scu_serial_checker.sv
// Purpose: port-level checks of the serial unit
// Assumes: one clock domain, reset active low
// Notes: bound to the top module below
`timescale 1ns/1ps
module scu_serial_checker
(
	// clock and reset
	input wire logic       CORE_CLK,
	input wire logic       RST_N,
	// controls
	input wire logic       SYNC_MODE,
	input wire logic       TX_WR,
	input wire logic       OVR_CLR,
	input wire logic       FER_CLR,
	// status
	input wire logic       TXD,
	input wire logic       TX_EMPTY,
	input wire logic       RX_FULL,
	input wire logic       OVERRUN,
	input wire logic       FRAMING_ERR,
	input wire logic       PARITY_ERR,
	input wire logic       RX_ERR_REQ,
	input wire logic [7:0] RX_HOLD
);
	default clocking cb @(posedge CORE_CLK);
	endclocking
	default disable iff (!RST_N);

	property p_err_or;
		RX_ERR_REQ == (OVERRUN || FRAMING_ERR || PARITY_ERR);
	endproperty
	a_err_or: assert property (p_err_or) else $error("error request not OR of flags");
	property p_wr_clear;
		TX_WR |=> !TX_EMPTY;
	endproperty
	a_wr_clear: assert property (p_wr_clear) else $error("write not taken");
	property p_empty_hold;
		TX_EMPTY && !TX_WR |=> TX_EMPTY;
	endproperty
	a_empty_hold: assert property (p_empty_hold) else $error("empty flag fell alone");
	property p_start;
		$rose(TX_EMPTY) && !SYNC_MODE |-> !TXD;
	endproperty
	a_start: assert property (p_start) else $error("no start bit at load");
	// overrun blocks every sync start, the byte waits
	property p_sync_block;
		SYNC_MODE && OVERRUN && !TX_EMPTY |=> !TX_EMPTY;
	endproperty
	a_sync_block: assert property (p_sync_block) else $error("sync start with overrun");
	property p_ovr_keep;
		$rose(OVERRUN) |-> RX_FULL && $stable(RX_HOLD);
	endproperty
	a_ovr_keep: assert property (p_ovr_keep) else $error("overrun touched holding");
	property p_ovr_sticky;
		OVERRUN && !OVR_CLR |=> OVERRUN;
	endproperty
	a_ovr_sticky: assert property (p_ovr_sticky) else $error("overrun flag lost");
	property p_fe_nofull;
		$rose(FRAMING_ERR) && !OVERRUN |-> !RX_FULL;
	endproperty
	a_fe_nofull: assert property (p_fe_nofull) else $error("full set with framing error");
	property p_full_clean;
		$rose(RX_FULL) |-> !$rose(FRAMING_ERR) && !$rose(PARITY_ERR);
	endproperty
	a_full_clean: assert property (p_full_clean) else $error("full set on bad frame");
	property p_fe_sticky;
		FRAMING_ERR && !FER_CLR |=> FRAMING_ERR;
	endproperty
	a_fe_sticky: assert property (p_fe_sticky) else $error("framing flag lost");

	c_overrun: cover property ($rose(OVERRUN));
	c_framing: cover property ($rose(FRAMING_ERR) && !OVERRUN);
	c_sync_wait: cover property (SYNC_MODE && OVERRUN && !TX_EMPTY);
endmodule : scu_serial_checker

bind scu_serial_unit scu_serial_checker scu_serial_checker_i (.CORE_CLK(CORE_CLK),
	.RST_N(RST_N), .SYNC_MODE(SYNC_MODE), .TX_WR(TX_WR), .OVR_CLR(OVR_CLR),
	.FER_CLR(FER_CLR), .TXD(TXD), .TX_EMPTY(TX_EMPTY), .RX_FULL(RX_FULL),
	.OVERRUN(OVERRUN), .FRAMING_ERR(FRAMING_ERR), .PARITY_ERR(PARITY_ERR),
	.RX_ERR_REQ(RX_ERR_REQ), .RX_HOLD(RX_HOLD));

//--- testbench/scu_line_peer.sv
// Purpose: far end of the line, sends frames and decodes TXD
// Assumes: BAUD_DIV 0, so a bit is 16 core clocks
// Notes: the line idles high like a pulled-up wire
`timescale 1ns/1ps
module scu_line_peer
(
	// line
	output logic      rxd,
	input  wire logic txd
);
	localparam int BIT_NS = 160;
	initial rxd = 1'b1;
	// a held low line is a break
	task automatic hold(input logic v);
		rxd = v;
	endtask : hold
	// last slot is the stop bit, or parity when parity is on
	task automatic send(input logic [7:0] d, input logic last);
		rxd = 1'b0;
		#(BIT_NS);
		for (int i = 0; i < 8; i++)
		begin
			rxd = d[i];
			#(BIT_NS);
		end
		rxd = last;
		#(BIT_NS);
		rxd = 1'b1;
		#(2 * BIT_NS);
	endtask : send
	task automatic recv(output logic [7:0] d);
		@(negedge txd);
		#(BIT_NS / 2);
		for (int i = 0; i < 8; i++)
		begin
			#(BIT_NS);
			d[i] = txd;
		end
		#(BIT_NS);
	endtask : recv
endmodule : scu_line_peer

//--- testbench/test_serial_rx_tx_error_handling.sv
// Purpose: self-checking bench of the serial unit
// Assumes: BAUD_DIV 0, 8 data bits, one stop bit
// Notes: st packs the status outputs for one-line compares
`timescale 1ns/1ps
module test_serial_rx_tx_error_handling;
	logic       clk = 1'b0;
	logic       rst_n = 1'b0;
	logic       sync_mode = 1'b0;
	logic       par_en = 1'b0;
	logic       par_odd = 1'b0;
	logic       tx_wr = 1'b0;
	logic [7:0] tx_data = 8'h00;
	logic [3:0] clr_m = 4'h0;
	logic       rx_ready = 1'b1;
	logic       tx_en = 1'b1;
	logic       rx_en = 1'b1;
	logic       rxd, txd, sck, tx_empty, rx_full, ovr, framing_error_flag, per, err_req, rx_valid;
	logic [7:0] rx_data, rx_hold;
	logic [7:0] got[$];
	int         num_errors = 0;
	int         n_tests = 0;
	// empty,full,overrun,framing,parity,request,valid,txd
	wire  [7:0] st = {tx_empty, rx_full, ovr, framing_error_flag, per, err_req, rx_valid, txd};

	always #5 clk = ~clk;

	scu_serial_unit scu_serial_unit_i (.CORE_CLK(clk), .RST_N(rst_n), .SYNC_MODE(sync_mode),
		.TX_EN(tx_en), .RX_EN(rx_en), .DATA7(1'b0), .PARITY_EN(par_en), .PARITY_ODD(par_odd),
		.TWO_STOP(1'b0), .BAUD_DIV(16'h0000), .TX_WR(tx_wr), .TX_DATA(tx_data),
		.RX_FULL_CLR(clr_m[3]), .OVR_CLR(clr_m[2]), .FER_CLR(clr_m[1]), .PER_CLR(clr_m[0]),
		.RX_DATA(rx_data), .RX_VALID(rx_valid), .RX_READY(rx_ready), .RXD(rxd), .TXD(txd),
		.SCK_OUT(sck), .TX_EMPTY(tx_empty), .RX_FULL(rx_full), .OVERRUN(ovr),
		.FRAMING_ERR(framing_error_flag), .PARITY_ERR(per), .RX_ERR_REQ(err_req), .RX_HOLD(rx_hold));
	scu_line_peer scu_line_peer_i (.rxd(rxd), .txd(txd));

	always @(posedge clk)
		if (rx_valid && rx_ready)
			got.push_back(rx_data);

	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : tick
	// strobe left high so back-to-back writes stay legal
	task automatic wr(input logic [7:0] d);
		tx_data = d;
		tx_wr = 1'b1;
		tick(1);
	endtask : wr
	task automatic clr(input logic [3:0] m);
		clr_m = m;
		tick(1);
		clr_m = 4'h0;
	endtask : clr
	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		n_tests++;
		if (g !== e)
		begin
			num_errors++;
			$display("mismatch at %0t: got %h expected %h", $time, g, e);
		end
	endtask : chk
	task automatic done(input string s);
		$display("%s test finished, %0d mismatches so far", s, num_errors);
	endtask : done
	task automatic close_out();
		$display("comparisons %0d mismatches %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : close_out

	initial
	begin
		// roughly three times the expected run length
		#(100_000);
		num_errors++;
		close_out();
	end

	initial
	begin
		logic [7:0] r0, r1;
		tick(16);
		rst_n = 1'b1;
		tick(4);
		chk(st, 8'h81);
		done("reset");
		fork
			begin
				scu_line_peer_i.recv(r0);
				scu_line_peer_i.recv(r1);
			end
			begin
				wr(8'h35);
				tx_wr = 1'b0;
				tick(20);
				wr(8'hc3);
				wr(8'h5a);
				tx_wr = 1'b0;
				chk(st & 8'h80, 8'h00);
			end
		join
		chk(r0, 8'h35);
		chk(r1, 8'h5a);
		tick(20);
		chk(st, 8'h81);
		done("overwrite");
		scu_line_peer_i.send(8'ha5, 1'b1);
		tick(2);
		chk(rx_hold, 8'ha5);
		chk(got.pop_front(), 8'ha5);
		chk(st, 8'h81);
		scu_line_peer_i.send(8'h3c, 1'b0);
		tick(2);
		chk(st, 8'h95);
		chk(rx_hold, 8'h3c);
		chk(8'(got.size()), 8'h00);
		clr(4'h2);
		par_en = 1'b1;
		scu_line_peer_i.send(8'h01, 1'b0);
		tick(2);
		chk(st, 8'h8d);
		chk(rx_hold, 8'h01);
		clr(4'h1);
		par_odd = 1'b1;
		scu_line_peer_i.send(8'h07, 1'b0);
		tick(2);
		chk(st, 8'h81);
		chk(got.pop_front(), 8'h07);
		par_en = 1'b0;
		par_odd = 1'b0;
		done("receive errors");
		// receiver stalls: two bytes fill the buffer, third stays held
		rx_ready = 1'b0;
		for (int i = 0; i < 3; i++)
			scu_line_peer_i.send(8'h10 + 8'(i), 1'b1);
		tick(2);
		chk(st, 8'hc3);
		scu_line_peer_i.send(8'h77, 1'b0);
		tick(2);
		chk(st, 8'hf7);
		chk(rx_hold, 8'h12);
		clr(4'h8);
		rx_ready = 1'b1;
		tick(4);
		chk(got.pop_front(), 8'h10);
		chk(got.pop_front(), 8'h11);
		chk(8'(got.size()), 8'h00);
		chk(st, 8'hb5);
		clr(4'h2);
		done("overrun");
		sync_mode = 1'b1;
		wr(8'h96);
		tx_wr = 1'b0;
		tick(40);
		chk(st & 8'he6, 8'h24);
		chk({7'h00, sck}, 8'h01);
		clr(4'h4);
		tick(3);
		chk(st & 8'h80, 8'h80);
		tick(200);
		chk(got.pop_front(), 8'hff);
		sync_mode = 1'b0;
		done("sync overrun");
		scu_line_peer_i.hold(1'b0);
		tick(200);
		chk(st, 8'h95);
		chk(rx_hold, 8'h00);
		clr(4'h2);
		tick(200);
		chk(st & 8'h10, 8'h10);
		scu_line_peer_i.hold(1'b1);
		tick(400);
		clr(4'h2);
		chk(st, 8'h81);
		done("break");
		// disabled paths: the write waits, a line frame is ignored
		tx_en = 1'b0;
		rx_en = 1'b0;
		wr(8'h42);
		tx_wr = 1'b0;
		scu_line_peer_i.send(8'h55, 1'b1);
		tick(2);
		chk(st, 8'h01);
		tx_en = 1'b1;
		tick(3);
		chk(st, 8'h80);
		done("enables");
		close_out();
	end
endmodule : test_serial_rx_tx_error_handling
